// ==== hw/ptp_flow_action.sv ====
// Per-flow action stage with common controls and egress frame signature builder
// How it works
// - Flow holds status byte position, gives packet offset
// - Status-update enable tells rewriter to update bit
// - Flow carries 4-bit rewrite byte count
// - Flow carries 8-bit rewrite position from SFD
// - Flow carries 8-bit correction field location
// - Per-channel enable bits gate each flow
// - Flow fields used only while flow enabled
// - Common bit picks checksum controls comparator one/two
// - Common 2-bit address source for signature
// - Source 0/1 Ethernet blocks, 2/3 IP blocks
// - Group mask must meet prior stage group hits
// - Chained comparator starts at least one word after protocol
// - Disabled engine reconfigurable; others keep running
// - Per-flow enable guards reconfiguration of flow
// - Comparators disableable; first_ethernet_comparator off stamps every frame
// - Enables change only between packets
// - Strict mode: disabled anywhere means disabled
// - Signature up to sixteen header/address bytes
// - Signature produced for egress frames only
// - Selects 0-23 header byte 31-sel; 24-26 fixed
// - Selects 28-35 address byte sel-28; 27 reserved
// - Sixteen 6-bit selects, byte 0 least significant
`timescale 1ns/10ps
`default_nettype none
`include "ptp_flow_action_cfg.svh"

module ptp_flow_action #(
    parameter int NUM_FLOWS    = 8,
    parameter int NUM_CHANNELS = 2,
    parameter int FI_W         = $clog2(NUM_FLOWS)
) (
    // Clock and reset
    input  wire logic                         sys_clk,
    input  wire logic                         resetn,
    // Wishbone register slave
    input  wire logic                         wb_cyc_i,
    input  wire logic                         wb_stb_i,
    input  wire logic                         wb_we_i,
    input  wire logic [3:0]                   wb_sel_i,
    input  wire logic [7:0]                   wb_adr_i,
    input  wire logic [31:0]                  wb_dat_i,
    output logic      [31:0]                  wb_dat_o,
    output logic                              wb_ack_o,
    // Frame framing and earlier comparator stages
    input  wire logic                         frame_start,
    input  wire logic                         frame_end,
    input  wire logic                         frame_decide,
    input  wire logic                         frame_egress,
    input  wire logic [$clog2(NUM_CHANNELS)-1:0] frame_channel,
    input  wire logic                         eth_header_found,
    input  wire logic [NUM_FLOWS-1:0]         stage_flow_hits,
    input  wire logic [NUM_FLOWS-1:0]         other_stage_flow_en,
    input  wire logic [1:0]                   prior_group_hits,
    input  wire logic [7:0]                   eth_header_len,
    // Signature sources
    input  wire logic [255:0]                 header_bytes,
    input  wire logic [63:0]                  first_ethernet_comparator_address,
    input  wire logic [63:0]                  eth2_address,
    input  wire logic [63:0]                  ip1_address,
    input  wire logic [63:0]                  ip2_address,
    // Action towards rewriter and time-stamp FIFO
    output logic                              action_valid,
    output logic                              flow_matched,
    output logic      [FI_W-1:0]              matched_flow,
    output logic                              timestamp_all,
    output logic                              mod_status_update_en,
    output logic      [2:0]                   mod_status_byte_pos,
    output logic      [7:0]                   mod_status_pkt_offset,
    output logic      [3:0]                   rewrite_byte_count,
    output logic      [7:0]                   rewrite_position,
    output logic      [7:0]                   updated_correction_location,
    output logic                              ip_checksum_source_select,
    output logic      [1:0]                   chain_start_words,
    output logic                              signature_valid,
    output logic      [127:0]                 signature
);
    import ptp_flow_action_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // Decoding helpers

    // Picks one signature byte from the header or the chosen address
    function automatic logic [7:0] sig_byte(input sig_sel_t sel, input logic [255:0] hdr,
                                            input logic [63:0] adr);
        logic [7:0] r;
        logic [5:0] i;
        r = 8'h00;
        i = 6'h00;
        if (sel <= `SEL_HDR_LAST) begin
            i = 6'h1F - sel;
            r = hdr[i[4:0]*8 +: 8];
        end else if (sel == `SEL_HDR6) begin
            r = hdr[6*8 +: 8];
        end else if (sel == `SEL_HDR4) begin
            r = hdr[4*8 +: 8];
        end else if (sel == `SEL_HDR0) begin
            r = hdr[7:0];
        end else if (sel >= `SEL_ADDR_FIRST && sel <= `SEL_ADDR_LAST) begin
            i = sel - `SEL_ADDR_FIRST;
            r = adr[i[2:0]*8 +: 8];
        end
        return r;
    endfunction : sig_byte

    // Byte-lane merge for Wishbone writes
    function automatic logic [31:0] lane_merge(input logic [31:0] old, input logic [31:0] nw,
                                               input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    ////////////////////////////////////////////////////////////////////////////////
    // Register storage: software copy and the copy the datapath uses

    logic [31:0]     ctrl_q;
    logic [31:0]     flow_q     [NUM_FLOWS];
    logic [31:0]     sigmap_q   [4];
    logic [31:0]     act_ctrl_q;
    logic [31:0]     act_flow_q [NUM_FLOWS];
    logic [31:0]     act_map_q  [4];
    frame_state_t    frame_q;
    logic            commit;
    logic            wb_req;
    logic            wb_wr;
    logic            last_found_q;
    logic [FI_W-1:0] last_flow_q;

    assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wb_wr  = wb_req && wb_we_i;

    // Frame tracking: configuration is copied only outside a frame
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            frame_q <= FR_IDLE;
        end else if (frame_start) begin
            frame_q <= FR_BUSY;
        end else if (frame_end) begin
            frame_q <= FR_IDLE;
        end
    end

    assign commit = (frame_q == FR_IDLE && !frame_start) || frame_end;

    // Common control register
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            ctrl_q <= `CTRL_RESET;
        end else if (wb_wr && wb_adr_i == `REG_CTRL) begin
            ctrl_q <= lane_merge(ctrl_q, wb_dat_i, wb_sel_i);
        end
    end

    // Per-flow registers and their active copies
    for (genvar f = 0; f < NUM_FLOWS; f++) begin : g_flow
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                flow_q[f] <= `FL_RESET;
            end else if (wb_wr && wb_adr_i == `REG_FLOW_BASE + 8'(f * 4)) begin
                flow_q[f] <= lane_merge(flow_q[f], wb_dat_i, wb_sel_i);
            end
        end

        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                act_flow_q[f] <= `FL_RESET;
            end else if (commit) begin
                act_flow_q[f] <= flow_q[f];
            end
        end
    end

    // Signature map registers and their active copies
    for (genvar m = 0; m < 4; m++) begin : g_map
        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                sigmap_q[m] <= `SIGMAP_RESET;
            end else if (wb_wr && wb_adr_i == `REG_SIGMAP_BASE + 8'(m * 4)) begin
                sigmap_q[m] <= lane_merge(sigmap_q[m], wb_dat_i, wb_sel_i);
            end
        end

        always_ff @(posedge sys_clk) begin
            if (!resetn) begin
                act_map_q[m] <= `SIGMAP_RESET;
            end else if (commit) begin
                act_map_q[m] <= sigmap_q[m];
            end
        end
    end

    // Active common controls
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            act_ctrl_q <= `CTRL_RESET;
        end else if (commit) begin
            act_ctrl_q <= ctrl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Wishbone answer: one cycle after the request, dropped the cycle after

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wb_ack_o <= 1'b0;
        end else begin
            wb_ack_o <= wb_req;
        end
    end

    // Read data; unmapped addresses read as zero
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            wb_dat_o <= 32'h0000_0000;
        end else if (wb_req && !wb_we_i) begin
            wb_dat_o <= 32'h0000_0000;
            if (wb_adr_i == `REG_CTRL) begin
                wb_dat_o <= ctrl_q;
            end else if (wb_adr_i == `REG_STATUS) begin
                wb_dat_o <= {25'h0, last_found_q, 4'(last_flow_q), act_ctrl_q[`CTRL_ENGINE_EN],
                             frame_q == FR_BUSY};
            end
            for (int m = 0; m < 4; m++) begin
                if (wb_adr_i == `REG_SIGMAP_BASE + 8'(m * 4)) begin
                    wb_dat_o <= sigmap_q[m];
                end
            end
            for (int f = 0; f < NUM_FLOWS; f++) begin
                if (wb_adr_i == `REG_FLOW_BASE + 8'(f * 4)) begin
                    wb_dat_o <= flow_q[f];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Flow eligibility and match selection

    logic [NUM_FLOWS-1:0] flow_hit;
    logic                 first_ethernet_comparator_en;
    logic                 engine_en;
    logic                 strict_en;

    assign first_ethernet_comparator_en   = act_ctrl_q[`CTRL_FIRST_ETHERNET_COMPARATOR_EN];
    assign engine_en = act_ctrl_q[`CTRL_ENGINE_EN];
    assign strict_en = act_ctrl_q[`CTRL_STRICT];

    for (genvar f = 0; f < NUM_FLOWS; f++) begin : g_hit
        logic [NUM_CHANNELS-1:0] chan;
        logic [1:0]              grp;
        logic                    en;
        assign chan = act_flow_q[f][`FL_CHAN_LSB +: NUM_CHANNELS];
        assign grp  = act_flow_q[f][`FL_GROUP_LSB +: 2];
        assign en   = act_flow_q[f][`FL_VALID]
                      && !(strict_en && !other_stage_flow_en[f]);
        assign flow_hit[f] = engine_en
                             && en && chan[frame_channel]
                             && stage_flow_hits[f]
                             && |(grp & prior_group_hits)
                             && (eth_header_found || !first_ethernet_comparator_en);
    end

    logic            any_hit;
    logic [FI_W-1:0] hit_idx;

    // Lowest numbered matching flow wins
    always_comb begin
        any_hit = 1'b0;
        hit_idx = '0;
        for (int f = NUM_FLOWS - 1; f >= 0; f--) begin
            if (flow_hit[f]) begin
                any_hit = 1'b1;
                hit_idx = FI_W'(f);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame signature

    logic [63:0]  sel_addr;
    logic [127:0] sig_d;
    logic [4:0]   sig_len;

    assign sig_len = act_ctrl_q[`CTRL_SIGLEN_LSB +: 5];

    // Address source decode
    always_comb begin
        unique case (addr_src_t'(act_ctrl_q[`CTRL_ADDR_SRC_LSB +: 2]))
            2'h0:    sel_addr = first_ethernet_comparator_address;
            2'h1:    sel_addr = eth2_address;
            2'h2:    sel_addr = ip1_address;
            2'h3:    sel_addr = ip2_address;
        endcase
    end

    for (genvar b = 0; b < `SIG_BYTES; b++) begin : g_sig
        sig_sel_t s;
        assign s = sig_sel_t'(act_map_q[b / 4][(b % 4) * 8 +: 6]);
        assign sig_d[b*8 +: 8] = (5'(b) < sig_len)
                                 ? sig_byte(s, header_bytes, sel_addr) : 8'h00;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Action outputs, captured at the decision strobe

    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            action_valid <= 1'b0;
        end else begin
            action_valid <= frame_decide;
        end
    end

    // Matched flow fields towards the rewriter
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            flow_matched                <= 1'b0;
            matched_flow                <= '0;
            mod_status_update_en        <= 1'b0;
            mod_status_byte_pos         <= 3'h0;
            mod_status_pkt_offset       <= 8'h00;
            rewrite_byte_count          <= 4'h0;
            rewrite_position            <= 8'h00;
            updated_correction_location <= 8'h00;
        end else if (frame_decide) begin
            flow_matched                <= any_hit;
            matched_flow                <= hit_idx;
            mod_status_update_en        <= any_hit && act_flow_q[hit_idx][`FL_UPD_EN];
            mod_status_byte_pos         <= act_flow_q[hit_idx][`FL_POS_LSB +: 3];
            mod_status_pkt_offset       <= eth_header_len
                                           + 8'(act_flow_q[hit_idx][`FL_POS_LSB +: 3]);
            rewrite_byte_count          <= act_flow_q[hit_idx][`FL_COUNT_LSB +: 4];
            rewrite_position            <= act_flow_q[hit_idx][`FL_REWR_LSB +: 8];
            updated_correction_location <= act_flow_q[hit_idx][`FL_CFLOC_LSB +: 8];
        end
    end

    // Status copy of the last decision
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            last_found_q <= 1'b0;
            last_flow_q  <= '0;
        end else if (frame_decide) begin
            last_found_q <= any_hit;
            last_flow_q  <= hit_idx;
        end
    end

    // Common controls and signature, egress only for the signature
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            timestamp_all             <= 1'b0;
            ip_checksum_source_select <= 1'b0;
            chain_start_words         <= `CHAIN_MIN_WORDS;
            signature_valid           <= 1'b0;
            signature                 <= 128'h0;
        end else begin
            timestamp_all             <= engine_en && !first_ethernet_comparator_en;
            ip_checksum_source_select <= act_ctrl_q[`CTRL_IPCHK_SEL];
            chain_start_words         <= (act_ctrl_q[`CTRL_CHAIN_LSB +: 2] < `CHAIN_MIN_WORDS)
                                         ? `CHAIN_MIN_WORDS : act_ctrl_q[`CTRL_CHAIN_LSB +: 2];
            signature_valid           <= frame_decide && frame_egress && engine_en;
            if (frame_decide) begin
                signature <= frame_egress ? sig_d : 128'h0;
            end
        end
    end

endmodule : ptp_flow_action
`default_nettype wire

// ==== hw/ptp_flow_action_cfg.svh ====
// Register offsets, field positions, reset values, select codes and chain start minimum of the flow action stage
`ifndef PTP_FLOW_ACTION_CFG_SVH
`define PTP_FLOW_ACTION_CFG_SVH

// Register byte offsets
`define REG_CTRL          8'h00
`define REG_STATUS        8'h04
`define REG_SIGMAP_BASE   8'h10
`define REG_FLOW_BASE     8'h40

// Common control register fields
`define CTRL_ENGINE_EN    0
`define CTRL_IPCHK_SEL    1
`define CTRL_ADDR_SRC_LSB 2
`define CTRL_STRICT       4
`define CTRL_FIRST_ETHERNET_COMPARATOR_EN      5
`define CTRL_CHAIN_LSB    6
`define CTRL_SIGLEN_LSB   8
`define CTRL_RESET        32'h0000_1020

// Per-flow action register fields
`define FL_POS_LSB        0
`define FL_UPD_EN         3
`define FL_COUNT_LSB      4
`define FL_REWR_LSB       8
`define FL_CFLOC_LSB      16
`define FL_CHAN_LSB       24
`define FL_VALID          26
`define FL_GROUP_LSB      27
`define FL_RESET          32'h0000_0000

// Signature map: four selects per word, one per byte lane
`define SIGMAP_RESET      32'h0000_0000
`define SIG_BYTES         16

// Select codes of the signature byte mapping
`define SEL_HDR_LAST      6'h17
`define SEL_HDR6          6'h18
`define SEL_HDR4          6'h19
`define SEL_HDR0          6'h1A
`define SEL_ADDR_FIRST    6'h1C
`define SEL_ADDR_LAST     6'h23

// Least distance of a chained comparator from the protocol start, in 64-bit words
`define CHAIN_MIN_WORDS   2'h1

`endif

// ==== hw/ptp_flow_action_pkg.sv ====
// Types shared by the flow action stage
package ptp_flow_action_pkg;
    typedef enum logic {FR_IDLE, FR_BUSY} frame_state_t;
    typedef logic [5:0] sig_sel_t;
    typedef logic [1:0] addr_src_t;
endpackage : ptp_flow_action_pkg

// ==== testbench/flow_action_props.sv ====
// Concurrent checks on the flow action stage ports
`timescale 1ns/10ps
`default_nettype none
module flow_action_props #(
    parameter int NUM_FLOWS = 8
) (
    input wire logic                 sys_clk,
    input wire logic                 resetn,
    input wire logic                 wb_ack_o,
    input wire logic                 frame_decide,
    input wire logic                 frame_egress,
    input wire logic                 eth_header_found,
    input wire logic [NUM_FLOWS-1:0] stage_flow_hits,
    input wire logic [7:0]           eth_header_len,
    input wire logic                 action_valid,
    input wire logic                 flow_matched,
    input wire logic                 timestamp_all,
    input wire logic                 mod_status_update_en,
    input wire logic [2:0]           mod_status_byte_pos,
    input wire logic [7:0]           mod_status_pkt_offset,
    input wire logic [1:0]           chain_start_words,
    input wire logic                 signature_valid,
    input wire logic [127:0]         signature
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    ////////////////////////////////////////////////////////////////////////
    property p_ack_pulse; wb_ack_o |=> !wb_ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack held longer than one cycle");
    property p_decide_answer; frame_decide |=> action_valid; endproperty
    a_decide_answer: assert property (p_decide_answer) else $error("no action after decide");
    property p_action_cause; action_valid |-> $past(frame_decide); endproperty
    a_action_cause: assert property (p_action_cause) else $error("action without decide");
    property p_sig_egress; signature_valid |-> action_valid && $past(frame_egress); endproperty
    a_sig_egress: assert property (p_sig_egress) else $error("signature on ingress frame");
    property p_ingress_zero; action_valid && !$past(frame_egress) |-> signature == 128'h0; endproperty
    a_ingress_zero: assert property (p_ingress_zero) else $error("ingress signature not zero");
    property p_upd_match; action_valid && !flow_matched |-> !mod_status_update_en; endproperty
    a_upd_match: assert property (p_upd_match) else $error("status update without match");
    property p_pkt_offset;
        action_valid && flow_matched |->
            mod_status_pkt_offset == 8'($past(eth_header_len) + 8'(mod_status_byte_pos));
    endproperty
    a_pkt_offset: assert property (p_pkt_offset) else $error("packet offset wrong");
    property p_hit_cause; action_valid && flow_matched |-> $past(stage_flow_hits) != '0; endproperty
    a_hit_cause: assert property (p_hit_cause) else $error("match without stage hit");
    property p_eth_found;
        action_valid && flow_matched && !timestamp_all |-> $past(eth_header_found);
    endproperty
    a_eth_found: assert property (p_eth_found) else $error("match without ethernet header");
    property p_chain_min; chain_start_words != 2'h0; endproperty
    a_chain_min: assert property (p_chain_min) else $error("chain start below one word");
    // Main scenarios
    c_match: cover property (action_valid && flow_matched && signature_valid);
    c_miss: cover property (action_valid && !flow_matched);
    c_stamp_all: cover property (action_valid && timestamp_all);
endmodule : flow_action_props
`default_nettype wire

// ==== testbench/ts_fifo_model.sv ====
// Time-stamp FIFO side model that counts egress signatures and keeps the latest one
`timescale 1ns/10ps
`default_nettype none
module ts_fifo_model (
    // Clock and reset
    input wire logic          sys_clk,
    input wire logic          resetn,
    // Action from the analyzer
    input wire logic          action_valid,
    input wire logic          signature_valid,
    input wire logic [127:0]  signature,
    // Stored state
    output logic     [7:0]    fifo_level,
    output logic     [127:0]  fifo_head
);
    // Push a signature only with an egress action
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            fifo_level <= 8'h00;
            fifo_head  <= 128'h0;
        end else if (action_valid && signature_valid) begin
            fifo_level <= fifo_level + 8'h01;
            fifo_head  <= signature;
        end
    end
endmodule : ts_fifo_model
`default_nettype wire

// ==== testbench/tb_top.sv ====
// Register and frame sequences for the flow action stage
`timescale 1ns/10ps
`default_nettype none
`include "ptp_flow_action_cfg.svh"
module tb_top;
    logic sys_clk = 1'b0, resetn = 1'b0, wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'hF;
    logic [7:0] wb_adr_i = 8'h00, stage_flow_hits = 8'h00, other_stage_flow_en = 8'hFF, eth_header_len = 8'h0E;
    logic [31:0] wb_dat_i = 32'h0, wb_dat_o, rd;
    logic frame_start = 1'b0, frame_end = 1'b0, frame_decide = 1'b0, frame_egress = 1'b0;
    logic frame_channel = 1'b0, eth_header_found = 1'b1;
    logic [1:0] prior_group_hits = 2'h0, chain_start_words, addr_src;
    logic [255:0] header_bytes;
    logic [63:0] first_ethernet_comparator_address, eth2_address, ip1_address, ip2_address;
    logic wb_ack_o, action_valid, flow_matched, timestamp_all, mod_status_update_en;
    logic ip_checksum_source_select, signature_valid;
    logic [2:0] matched_flow, mod_status_byte_pos;
    logic [3:0] rewrite_byte_count;
    logic [7:0] mod_status_pkt_offset, rewrite_position, updated_correction_location, fifo_level;
    logic [127:0] signature, fifo_head;
    int bad_count = 0, compares = 0;
    always #50 sys_clk = ~sys_clk;
    ptp_flow_action uut (.sys_clk(sys_clk), .resetn(resetn), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .frame_start(frame_start), .frame_end(frame_end), .frame_decide(frame_decide),
        .frame_egress(frame_egress), .frame_channel(frame_channel), .eth_header_found(eth_header_found),
        .stage_flow_hits(stage_flow_hits), .other_stage_flow_en(other_stage_flow_en),
        .prior_group_hits(prior_group_hits), .eth_header_len(eth_header_len), .header_bytes(header_bytes),
        .first_ethernet_comparator_address(first_ethernet_comparator_address), .eth2_address(eth2_address), .ip1_address(ip1_address),
        .ip2_address(ip2_address), .action_valid(action_valid), .flow_matched(flow_matched),
        .matched_flow(matched_flow), .timestamp_all(timestamp_all), .mod_status_update_en(mod_status_update_en),
        .mod_status_byte_pos(mod_status_byte_pos), .mod_status_pkt_offset(mod_status_pkt_offset),
        .rewrite_byte_count(rewrite_byte_count), .rewrite_position(rewrite_position),
        .updated_correction_location(updated_correction_location),
        .ip_checksum_source_select(ip_checksum_source_select), .chain_start_words(chain_start_words),
        .signature_valid(signature_valid), .signature(signature));
    ts_fifo_model u_fifo (.sys_clk(sys_clk), .resetn(resetn), .action_valid(action_valid),
        .signature_valid(signature_valid), .signature(signature), .fifo_level(fifo_level), .fifo_head(fifo_head));
    ////////////////////////////////////////////////////////////////////////
    // Verdict and end of run
    task automatic finish_test;
        $display("errors=%0d compares=%0d", bad_count, compares);
        if (bad_count == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test
    // Compare one value
    task automatic chk(input logic [127:0] seen, input logic [127:0] exp);
        compares++;
        if (seen !== exp) begin
            bad_count++;
            $display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    // One classic Wishbone cycle, held until ack is sampled
    task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat);
        int n;
        @(posedge sys_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, we, adr, dat};
        for (n = 0; n < 20; n++) begin
            @(posedge sys_clk);
            if (wb_ack_o === 1'b1) break;
        end
        if (n == 20) begin
            bad_count++;
            finish_test();
        end
        rd = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask : wb
    // One frame; optional flow rewrite while it is open
    task automatic frame(input logic ch, egr, input logic [7:0] hits, input logic [1:0] grp,
                         input logic mid = 1'b0);
        @(posedge sys_clk);
        {frame_start, frame_channel, frame_egress, stage_flow_hits, prior_group_hits} <= {1'b1, ch, egr, hits, grp};
        @(posedge sys_clk);
        frame_start <= 1'b0;
        if (mid) wb(1'b1, `REG_FLOW_BASE, 32'h0908_2C8D);
        @(posedge sys_clk);
        frame_decide <= 1'b1;
        @(posedge sys_clk);
        frame_decide <= 1'b0;
        #1;
        chk(action_valid, 1'b1);
        chk(signature_valid, egr);
        @(posedge sys_clk);
        frame_end <= 1'b1;
        @(posedge sys_clk);
        frame_end <= 1'b0;
    endtask : frame
    initial begin
        for (int i = 0; i < 32; i++) header_bytes[8*i +: 8] = 8'h80 + 8'(i);
        for (int k = 0; k < 8; k++) begin
            first_ethernet_comparator_address[8*k +: 8] = 8'h10 + 8'(k);
            eth2_address[8*k +: 8] = 8'h20 + 8'(k);
            ip1_address[8*k +: 8]  = 8'h30 + 8'(k);
            ip2_address[8*k +: 8]  = 8'h40 + 8'(k);
        end
        repeat (6) @(posedge sys_clk);
        resetn <= 1'b1;
        #1 chk(chain_start_words, 2'h1);
        wb(1'b0, `REG_CTRL, 32'h0);
        chk(rd, `CTRL_RESET);
        wb(1'b0, 8'hFC, 32'h0);
        chk(rd, 32'h0);
        // Flow 0: pos 5, update, 8 bytes, 0x2C, 0x08, channel 0, enabled, group A
        wb(1'b1, `REG_FLOW_BASE, 32'h0D08_2C8D);
        wb(1'b0, `REG_FLOW_BASE, 32'h0);
        chk(rd, 32'h0D08_2C8D);
        wb(1'b1, `REG_SIGMAP_BASE, 32'h1B1C_1800);
        // Every address source, engine off while common bits change
        for (int s = 0; s < 4; s++) begin
            addr_src = 2'(s);
            wb(1'b1, `REG_CTRL, 32'h0000_0420);
            wb(1'b1, `REG_CTRL, {28'h000_0042, addr_src, 2'b11});
            frame(1'b0, 1'b1, 8'h01, 2'h1);
            chk(signature, {96'h0, 8'h00, 8'h10 * (8'(s) + 8'h01), 8'h86, 8'h9F});
            chk(fifo_head, {96'h0, 8'h00, 8'h10 * (8'(s) + 8'h01), 8'h86, 8'h9F});
        end
        chk(fifo_level, 8'h04);
        chk(ip_checksum_source_select, 1'b1);
        chk({flow_matched, matched_flow, mod_status_update_en}, 5'b1_000_1);
        chk({mod_status_byte_pos, mod_status_pkt_offset}, {3'h5, 8'h13});
        chk({rewrite_byte_count, rewrite_position, updated_correction_location}, 20'h8_2C_08);
        frame(1'b1, 1'b1, 8'h01, 2'h1);
        chk({flow_matched, mod_status_update_en}, 2'b00);
        frame(1'b0, 1'b1, 8'h01, 2'h2);
        chk(flow_matched, 1'b0);
        frame(1'b0, 1'b0, 8'h01, 2'h1);
        chk({flow_matched, signature}, {1'b1, 128'h0});
        eth_header_found <= 1'b0;
        frame(1'b0, 1'b1, 8'h01, 2'h1);
        chk(flow_matched, 1'b0);
        wb(1'b1, `REG_CTRL, 32'h0000_0400);
        wb(1'b1, `REG_CTRL, 32'h0000_040B);
        frame(1'b0, 1'b1, 8'h01, 2'h1);
        chk({timestamp_all, flow_matched}, 2'b11);
        eth_header_found <= 1'b1;
        wb(1'b1, `REG_CTRL, 32'h0000_0420);
        wb(1'b1, `REG_CTRL, 32'h0000_043B);
        other_stage_flow_en <= 8'hFE;
        frame(1'b0, 1'b1, 8'h01, 2'h1);
        chk(flow_matched, 1'b0);
        other_stage_flow_en <= 8'hFF;
        frame(1'b0, 1'b1, 8'h01, 2'h1, 1'b1);
        chk(flow_matched, 1'b1);
        frame(1'b0, 1'b1, 8'h01, 2'h1);
        chk(flow_matched, 1'b0);
        finish_test();
    end
    // Cut a hung run short
    initial begin
        #2_000_000;
        bad_count++;
        finish_test();
    end
endmodule : tb_top
bind ptp_flow_action flow_action_props #(.NUM_FLOWS(NUM_FLOWS)) u_props (.*);
`default_nettype wire
